// File: verilog/cts_checker.sv
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Phase-encoded sector: 16 zero preamble, sync one, 8 number, 144 data, 8 check.
// RQ2: Byte 0 must be 0 110 0 010; anything else prohibited.
// RQ3: Byte 1 bits 7,3 zero; ECC 010 or 011; size exponent 011 or 100.
// RQ4: Byte 2 is 6 for 4096-byte media, 7 for 2048-byte media.
// RQ5: Byte 4 bit 7 must be one.
// RQ6: Byte 4 bits 6..0 negative two's complement amplitude from -15 to -33.
// RQ7: Byte 5 capacity must be 5C.
// RQ8: Byte 6 read power value must lie from 60 to 80.
// RQ9: Byte 7 is 20 rewritable or 11 write once; else prohibited.
// RQ10: Byte 8 must be FE; byte 9 is 93 or 6B by sector size.
// RQ11: Byte 10 is 6D or 4C by sector size.
// RQ12: Byte 11 is 79 or E9 by sector size.
// RQ13: Byte 12 track pitch must be 41.
// RQ14: Byte 13 must be FF.
// RQ15: Byte 14 must be FF; forms outer start track with bytes 8, 9.
// RQ16: Byte 15 is 01 or 02; forms inner start track with bytes 10, 11.
// RQ17: Bytes 16 and 17 are not checked.
// RQ18: Check value covers sector number and data only, not preamble or sync.
// RQ19: Generator x^8+x^4+x^3+x^2+1, message multiplied by x^8.
// RQ20: Sector number inverted and first, MSB first; data bits not inverted.
// RQ21: Remainder bit 7 is the check byte's MSB.
// RQ22: Format-zone sector: 18 duplicate, 362 media, 132 system bytes.
// RQ23: Then FF padding: 1536 bytes for 2048 sectors, 3584 for 4096.
// RQ24: Format-zone bytes 0..17 must equal stored data bytes; mismatch flagged.
// RQ25: Sticky error on check mismatch or prohibited field, cleared at sector start.
module cts_checker
  import cts_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  // Demodulated phase-encoded bits
  input  wire logic             pep_bit_valid_i,
  input  wire logic             pep_bit_i,
  // Format-zone sector bytes
  input  wire logic             sfz_start_i,
  input  wire logic             sfz_byte_valid_i,
  input  wire logic [7:0]       sfz_byte_i,
  // Results
  output logic                  sector_done_o,
  output logic                  sfz_done_o,
  output logic                  err_o,
  output logic [23:0]           outer_track_o,
  output logic [23:0]           inner_track_o,
  // Register bus
  input  wire cts_axi_req_type  axi_req_i,
  output cts_axi_resp_type      axi_resp_o
);

  typedef logic [DATA_BYTES-1:0][7:0] cts_bytes_type;

  // Serial step of the sector check value
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic       b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00); // see RQ19
  endfunction : crc_step

  // One bit per data byte set when the byte is prohibited
  function automatic logic [DATA_BYTES-1:0] field_errs(
      input cts_bytes_type d);
    logic k4;
    logic k2;
    field_errs = '0;
    k4 = (d[1][2:0] == SIZE_EXP_4K);
    k2 = (d[1][2:0] == SIZE_EXP_2K);
    field_errs[0] = (d[0] != B0_VALUE); // see RQ2
    field_errs[1] = d[1][7] | d[1][3] | !(k4 | k2) |
                    !((d[1][6:4] == ECC_20_ILV) |
                      (d[1][6:4] == ECC_40_ILV)); // see RQ3
    field_errs[2] = k4 ? (d[2] != SPT_4K) : (d[2] != SPT_2K); // see RQ4
    field_errs[4] = !d[4][7] | !d[4][6] |
                    (d[4][6:0] < AMP_MIN) |
                    (d[4][6:0] > AMP_MAX); // see RQ5 see RQ6
    field_errs[5] = (d[5] != CAPACITY); // see RQ7
    field_errs[6] = (d[6] < RD_PWR_MIN) | (d[6] > RD_PWR_MAX); // see RQ8
    field_errs[7] = (d[7] != TYPE_REWRITE) &
                    (d[7] != TYPE_WR_ONCE); // see RQ9
    field_errs[8] = (d[8] != OUTER_MID); // see RQ10
    field_errs[9] = d[9] != (k4 ? OUTER_LOW_4K : OUTER_LOW_2K); // see RQ10
    field_errs[10] = d[10] != (k4 ? INNER_MID_4K : INNER_MID_2K); // see RQ11
    field_errs[11] = d[11] != (k4 ? INNER_LOW_4K : INNER_LOW_2K); // see RQ12
    field_errs[12] = (d[12] != TRACK_PITCH); // see RQ13
    field_errs[13] = (d[13] != FILL_BYTE); // see RQ14
    field_errs[14] = (d[14] != OUTER_HIGH); // see RQ15
    field_errs[15] = d[15] != (k4 ? INNER_HIGH_4K : INNER_HIGH_2K); // see RQ16
    // Bytes 3, 16 and 17 stay clear; see RQ17
  endfunction : field_errs

  cts_pep_state_type     state_q;
  logic [4:0]            zero_cnt_q;
  logic [7:0]            bit_cnt_q;
  logic [7:0]            secnum_q;
  logic [7:0]            crc_calc_q;
  logic [7:0]            crc_rx_q;
  cts_bytes_type         data_q;
  logic [DATA_BYTES-1:0] fields_q;
  logic                  crc_ok_q;
  logic                  captured_q;
  logic                  pep_start;
  logic                  pep_end;
  logic [7:0]            crc_rx_d;
  logic [1:0]            ctrl_q;
  logic                  dup_err_q;
  logic                  pad_err_q;
  logic                  sfz_busy_q;
  logic [12:0]           sfz_cnt_q;
  logic [12:0]           sfz_last;
  logic                  sfz_last_byte;
  logic                  sfz_take;

  assign pep_start = ctrl_q[0] && pep_bit_valid_i && state_q == PS_HUNT &&
                     pep_bit_i && zero_cnt_q == 5'(PREAMBLE_BITS); // see RQ1
  assign crc_rx_d  = {crc_rx_q[6:0], pep_bit_i};
  assign pep_end   = ctrl_q[0] && pep_bit_valid_i && state_q == PS_CRC &&
                     bit_cnt_q == 8'(CRC_BITS - 1);

  // Phase-encoded sector framing
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q    <= PS_HUNT;
      zero_cnt_q <= '0;
      bit_cnt_q  <= '0;
    end else if (ctrl_q[0] && pep_bit_valid_i) begin
      unique case (state_q)
        PS_HUNT: begin
          if (!pep_bit_i) begin
            if (zero_cnt_q != 5'(PREAMBLE_BITS)) begin
              zero_cnt_q <= zero_cnt_q + 5'h01;
            end
          end else begin
            zero_cnt_q <= '0;
            if (pep_start) begin
              state_q   <= PS_SECNUM;
              bit_cnt_q <= '0;
            end
          end
        end
        PS_SECNUM: begin
          bit_cnt_q <= bit_cnt_q + 8'h01;
          if (bit_cnt_q == 8'(SECNUM_BITS - 1)) begin
            state_q   <= PS_DATA;
            bit_cnt_q <= '0;
          end
        end
        PS_DATA: begin
          bit_cnt_q <= bit_cnt_q + 8'h01;
          if (bit_cnt_q == 8'(DATA_BITS - 1)) begin
            state_q   <= PS_CRC;
            bit_cnt_q <= '0;
          end
        end
        PS_CRC: begin
          bit_cnt_q <= bit_cnt_q + 8'h01;
          if (pep_end) begin
            state_q <= PS_HUNT;
          end
        end
      endcase
    end
  end

  // Field capture and check value
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      secnum_q   <= '0;
      crc_calc_q <= CRC_INIT;
      crc_rx_q   <= '0;
      data_q     <= '0;
    end else if (ctrl_q[0] && pep_bit_valid_i) begin
      unique case (state_q)
        PS_HUNT: begin
          if (pep_start) begin
            crc_calc_q <= CRC_INIT; // see RQ18
          end
        end
        PS_SECNUM: begin
          secnum_q   <= {secnum_q[6:0], pep_bit_i};
          crc_calc_q <= crc_step(crc_calc_q, !pep_bit_i); // see RQ20
        end
        PS_DATA: begin
          data_q[bit_cnt_q[7:3]][3'h7 - bit_cnt_q[2:0]] <= pep_bit_i;
          crc_calc_q <= crc_step(crc_calc_q, pep_bit_i); // see RQ20
        end
        PS_CRC: begin
          crc_rx_q <= crc_rx_d; // see RQ21
        end
      endcase
    end
  end

  // Verdict at the end of each sector
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fields_q      <= '0;
      crc_ok_q      <= 1'b0;
      captured_q    <= 1'b0;
      sector_done_o <= 1'b0;
      outer_track_o <= '0;
      inner_track_o <= '0;
    end else begin
      sector_done_o <= pep_end;
      if (pep_end) begin
        fields_q      <= field_errs(data_q);
        crc_ok_q      <= (crc_rx_d == crc_calc_q); // see RQ21
        captured_q    <= 1'b1;
        outer_track_o <= {data_q[14], data_q[8], data_q[9]}; // see RQ15
        inner_track_o <= {data_q[15], data_q[10], data_q[11]}; // see RQ16
      end
    end
  end

  // Sticky error; a set in the same cycle wins over a start
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_o <= 1'b0;
    end else if (pep_end && ((crc_rx_d != crc_calc_q) ||
                             (field_errs(data_q) != '0))) begin
      err_o <= 1'b1; // see RQ25
    end else if (sfz_take && (dup_err_q || pad_err_q)) begin
      err_o <= 1'b1; // see RQ25
    end else if (pep_start || (ctrl_q[1] && sfz_start_i)) begin
      err_o <= 1'b0; // see RQ25
    end
  end

  // Format-zone control sector length by sector size
  assign sfz_last = (data_q[1][2:0] == SIZE_EXP_4K) ?
                    13'(SFZ_INFO_BYTES + SFZ_PAD_4K - 1) :
                    13'(SFZ_INFO_BYTES + SFZ_PAD_2K - 1); // see RQ23
  assign sfz_last_byte = sfz_busy_q && sfz_byte_valid_i &&
                         sfz_cnt_q == sfz_last;
  assign sfz_take = sfz_done_o;

  // Format-zone byte comparison
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfz_busy_q <= 1'b0;
      sfz_cnt_q  <= '0;
      dup_err_q  <= 1'b0;
      pad_err_q  <= 1'b0;
      sfz_done_o <= 1'b0;
    end else begin
      sfz_done_o <= sfz_last_byte;
      if (ctrl_q[1] && sfz_start_i) begin
        sfz_busy_q <= 1'b1;
        sfz_cnt_q  <= '0;
        dup_err_q  <= 1'b0;
        pad_err_q  <= 1'b0;
      end else if (sfz_busy_q && sfz_byte_valid_i) begin
        sfz_cnt_q <= sfz_cnt_q + 13'h0001;
        if (sfz_cnt_q < 13'(DATA_BYTES) &&
            sfz_byte_i != data_q[sfz_cnt_q[4:0]]) begin
          dup_err_q <= 1'b1; // see RQ24
        end
        if (sfz_cnt_q >= 13'(SFZ_INFO_BYTES) &&
            sfz_byte_i != FILL_BYTE) begin
          pad_err_q <= 1'b1; // see RQ22 see RQ23
        end
        if (sfz_last_byte) begin
          sfz_busy_q <= 1'b0;
        end
      end
    end
  end

  // Register bus slave
  logic        awready_q;
  logic        wready_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_go;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awready_q && axi_req_i.awvalid) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q  <= axi_req_i.awaddr;
      end
      if (wready_q && axi_req_i.wvalid) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q  <= axi_req_i.wdata;
        wstrb_q  <= axi_req_i.wstrb;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bresp_q   <= (awaddr_q <= REG_DATA4 && awaddr_q[1:0] == 2'h0) ?
                     RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && axi_req_i.bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Control register: bit 0 enables bits, bit 1 enables bytes
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_go && awaddr_q == REG_CTRL && wstrb_q[0]) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    unique case (axi_req_i.araddr)
      REG_CTRL:   rd_word = {30'h0, ctrl_q};
      REG_STATUS: rd_word = {crc_rx_q, crc_calc_q, secnum_q,
                             state_q != PS_HUNT, 1'b0, sfz_busy_q,
                             pad_err_q, dup_err_q, err_o, crc_ok_q,
                             captured_q};
      REG_FIELDS: rd_word = {data_q[7] == TYPE_WR_ONCE, 13'h0, fields_q};
      REG_OUTER:  rd_word = {8'h0, outer_track_o};
      REG_INNER:  rd_word = {8'h0, inner_track_o};
      8'h14:      rd_word = {data_q[3], data_q[2], data_q[1], data_q[0]};
      8'h18:      rd_word = {data_q[7], data_q[6], data_q[5], data_q[4]};
      8'h1C:      rd_word = {data_q[11], data_q[10], data_q[9], data_q[8]};
      8'h20:      rd_word = {data_q[15], data_q[14], data_q[13],
                             data_q[12]};
      REG_DATA4:  rd_word = {16'h0, data_q[17], data_q[16]};
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (arready_q && axi_req_i.arvalid) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axi_req_i.rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign axi_resp_o.awready = awready_q;
  assign axi_resp_o.wready  = wready_q;
  assign axi_resp_o.bvalid  = bvalid_q;
  assign axi_resp_o.bresp   = bresp_q;
  assign axi_resp_o.arready = arready_q;
  assign axi_resp_o.rvalid  = rvalid_q;
  assign axi_resp_o.rdata   = rdata_q;
  assign axi_resp_o.rresp   = rresp_q;

endmodule : cts_checker

// File: shared/cts_pkg.sv
package cts_pkg;

  // Sector layout of the phase-encoded zone
  localparam int PREAMBLE_BITS = 16;
  localparam int SECNUM_BITS   = 8;
  localparam int DATA_BYTES    = 18;
  localparam int DATA_BITS     = 144;
  localparam int CRC_BITS      = 8;

  // Check value generator x^8+x^4+x^3+x^2+1, low terms only
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Media parameter encodings
  localparam logic [7:0] B0_VALUE      = 8'h62;
  localparam logic [2:0] ECC_20_ILV    = 3'h2;
  localparam logic [2:0] ECC_40_ILV    = 3'h3;
  localparam logic [2:0] SIZE_EXP_2K   = 3'h3;
  localparam logic [2:0] SIZE_EXP_4K   = 3'h4;
  localparam logic [7:0] SPT_4K        = 8'h06;
  localparam logic [7:0] SPT_2K        = 8'h07;
  localparam logic [6:0] AMP_MIN       = 7'h5F;
  localparam logic [6:0] AMP_MAX       = 7'h71;
  localparam logic [7:0] CAPACITY      = 8'h5C;
  localparam logic [7:0] RD_PWR_MIN    = 8'h3C;
  localparam logic [7:0] RD_PWR_MAX    = 8'h50;
  localparam logic [7:0] TYPE_REWRITE  = 8'h20;
  localparam logic [7:0] TYPE_WR_ONCE  = 8'h11;
  localparam logic [7:0] OUTER_MID     = 8'hFE;
  localparam logic [7:0] OUTER_LOW_4K  = 8'h93;
  localparam logic [7:0] OUTER_LOW_2K  = 8'h6B;
  localparam logic [7:0] INNER_MID_4K  = 8'h6D;
  localparam logic [7:0] INNER_MID_2K  = 8'h4C;
  localparam logic [7:0] INNER_LOW_4K  = 8'h79;
  localparam logic [7:0] INNER_LOW_2K  = 8'hE9;
  localparam logic [7:0] TRACK_PITCH   = 8'h41;
  localparam logic [7:0] FILL_BYTE     = 8'hFF;
  localparam logic [7:0] OUTER_HIGH    = 8'hFF;
  localparam logic [7:0] INNER_HIGH_4K = 8'h01;
  localparam logic [7:0] INNER_HIGH_2K = 8'h02;

  // Format-zone control sector layout
  localparam int SFZ_INFO_BYTES = 512;
  localparam int SFZ_PAD_2K     = 1536;
  localparam int SFZ_PAD_4K     = 3584;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FIELDS = 8'h08;
  localparam logic [7:0] REG_OUTER  = 8'h0C;
  localparam logic [7:0] REG_INNER  = 8'h10;
  localparam logic [7:0] REG_DATA0  = 8'h14;
  localparam logic [7:0] REG_DATA4  = 8'h24;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PS_HUNT, PS_SECNUM, PS_DATA, PS_CRC
  } cts_pep_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cts_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cts_axi_resp_type;

endpackage : cts_pkg

// File: verif/cts_checker_properties.sv
`timescale 1ns/1ns
module cts_checker_properties
  import cts_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Stream inputs
  input  wire logic        pep_bit_valid_i,
  input  wire logic        pep_bit_i,
  input  wire logic        sfz_start_i,
  input  wire logic        sfz_byte_valid_i,
  // Results
  input  wire logic        sector_done_o,
  input  wire logic        sfz_done_o,
  input  wire logic        err_o,
  input  wire logic [23:0] outer_track_o,
  input  wire logic [23:0] inner_track_o
);
  logic [4:0]  zero_q;
  logic [12:0] cnt_q;
  logic        sync_c;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) zero_q <= '0;
    else if (pep_bit_valid_i && pep_bit_i) zero_q <= 5'h00;
    else if (pep_bit_valid_i && zero_q != 5'h10) zero_q <= zero_q + 5'h01;
  end
  assign sync_c = pep_bit_valid_i && pep_bit_i && (zero_q == 5'h10);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= '0;
    else if (sfz_start_i) cnt_q <= '0;
    else if (sfz_byte_valid_i) cnt_q <= cnt_q + 13'h0001;
  end

  property p_sec_pulse; sector_done_o |=> !sector_done_o; endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("sector done too long");
  property p_sec_cause; sector_done_o |-> $past(pep_bit_valid_i); endproperty
  a_sec_cause: assert property (p_sec_cause)
    else $error("sector done without bit");
  property p_sfz_pulse; sfz_done_o |=> !sfz_done_o; endproperty
  a_sfz_pulse: assert property (p_sfz_pulse)
    else $error("format done too long");
  property p_sfz_len;
    sfz_done_o |-> (cnt_q == 13'd2048 || cnt_q == 13'd4096);
  endproperty
  a_sfz_len: assert property (p_sfz_len)
    else $error("format length wrong");
  property p_err_rise;
    $rose(err_o) |-> sector_done_o || $past(sfz_done_o);
  endproperty
  a_err_rise: assert property (p_err_rise)
    else $error("error set off sector end");
  property p_err_fall;
    $fell(err_o) |-> $past(sfz_start_i) || $past(sync_c);
  endproperty
  a_err_fall: assert property (p_err_fall)
    else $error("error cleared off start");
  property p_sfz_clear; sfz_start_i |=> !err_o || sector_done_o; endproperty
  a_sfz_clear: assert property (p_sfz_clear)
    else $error("error kept over start");
  property p_outer_hold; !sector_done_o |-> $stable(outer_track_o); endproperty
  a_outer_hold: assert property (p_outer_hold)
    else $error("outer track moved");
  property p_inner_hold; !sector_done_o |-> $stable(inner_track_o); endproperty
  a_inner_hold: assert property (p_inner_hold)
    else $error("inner track moved");

  c_bad_sec: cover property (sector_done_o && err_o);
  c_good_sfz: cover property (sfz_done_o && !err_o);
  c_err_clr: cover property ($fell(err_o));
endmodule : cts_checker_properties

bind cts_checker cts_checker_properties cts_checker_properties_inst (
  .sys_clk_i, .rstn_i, .pep_bit_valid_i, .pep_bit_i, .sfz_start_i,
  .sfz_byte_valid_i, .sector_done_o, .sfz_done_o, .err_o,
  .outer_track_o, .inner_track_o
);

// File: verif/cts_demod_model.sv
`timescale 1ns/1ns
module cts_demod_model
  import cts_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  // Sector to send
  input  wire logic         go_i,
  input  wire logic         slow_i,
  input  wire logic [7:0]   secnum_i,
  input  wire logic [143:0] data_i,
  input  wire logic [7:0]   crc_i,
  // Demodulated bits
  output logic              bit_valid_o,
  output logic              bit_o
);
  logic [176:0] sh_q;
  logic [7:0]   left_q;
  logic         idle_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_q        <= '0;
      left_q      <= 8'h00;
      idle_q      <= 1'b0;
      bit_valid_o <= 1'b0;
      bit_o       <= 1'b0;
    end else if (go_i) begin
      sh_q        <= {16'h0000, 1'b1, secnum_i, data_i, crc_i};
      left_q      <= 8'hB1;
      bit_valid_o <= 1'b0;
    end else if (left_q != 8'h00 && !(slow_i && !idle_q)) begin
      bit_valid_o <= 1'b1;
      bit_o       <= sh_q[176];
      sh_q        <= {sh_q[175:0], 1'b0};
      left_q      <= left_q - 8'h01;
      idle_q      <= 1'b0;
    end else begin
      bit_valid_o <= 1'b0;
      bit_o       <= ~bit_o;
      idle_q      <= 1'b1;
    end
  end
endmodule : cts_demod_model

// File: verif/test_control_track_sector_checker.sv
`timescale 1ns/1ns
module test_control_track_sector_checker
  import cts_pkg::*;
;
  logic             sys_clk_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic             sfz_start, sfz_valid, dm_go, dm_slow;
  logic [7:0]       sfz_byte, dm_sec, dm_crc;
  logic [143:0]     dm_dat, cur;
  logic             bit_valid, bit_val, sec_done, sfz_done, err;
  logic [23:0]      outer, inner;
  cts_axi_req_type  axi_req;
  cts_axi_resp_type axi_resp;
  int               errors = 0;
  int               check_count = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  cts_demod_model cts_demod_model_inst (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .go_i(dm_go), .slow_i(dm_slow), .secnum_i(dm_sec),
    .data_i(dm_dat), .crc_i(dm_crc), .bit_valid_o(bit_valid),
    .bit_o(bit_val));
  cts_checker cts_checker_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .pep_bit_valid_i(bit_valid), .pep_bit_i(bit_val),
    .sfz_start_i(sfz_start), .sfz_byte_valid_i(sfz_valid),
    .sfz_byte_i(sfz_byte), .sector_done_o(sec_done), .sfz_done_o(sfz_done),
    .err_o(err), .outer_track_o(outer), .inner_track_o(inner),
    .axi_req_i(axi_req), .axi_resp_o(axi_resp));

  function automatic logic [7:0] crc_of(input logic [7:0] s,
                                        input logic [143:0] d);
    logic [151:0] m;
    logic [7:0]   r;
    m = {~s, d};
    r = 8'h00;
    for (int i = 151; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((m[i] ^ r[7]) ? 8'h1D : 8'h00);
    end
    return r;
  endfunction : crc_of

  function automatic logic [143:0] media(input logic big);
    media = {B0_VALUE, 1'b0, big ? ECC_20_ILV : ECC_40_ILV, 1'b0,
      big ? SIZE_EXP_4K : SIZE_EXP_2K, big ? SPT_4K : SPT_2K, 8'h55,
      big ? 8'hDF : 8'hF1, CAPACITY, big ? RD_PWR_MIN : RD_PWR_MAX,
      big ? TYPE_REWRITE : TYPE_WR_ONCE, OUTER_MID,
      big ? OUTER_LOW_4K : OUTER_LOW_2K, big ? INNER_MID_4K : INNER_MID_2K,
      big ? INNER_LOW_4K : INNER_LOW_2K, TRACK_PITCH, FILL_BYTE, OUTER_HIGH,
      big ? INNER_HIGH_4K : INNER_HIGH_2K, 8'hA5, 8'h3C};
  endfunction : media

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk_i);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (axi_resp.awready) axi_req.awvalid <= 1'b0;
      if (axi_resp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_resp.bvalid !== 1'b1);
    r = axi_resp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk_i);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (axi_resp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_resp.rvalid !== 1'b1);
    d = axi_resp.rdata;
    r = axi_resp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_rd

  task automatic send_sec(input logic [7:0] s, input logic [143:0] d,
                          input logic [7:0] flip, input logic slow,
                          input logic exp);
    cur = d;
    @(posedge sys_clk_i);
    dm_sec  <= s;
    dm_dat  <= d;
    dm_crc  <= crc_of(s, d) ^ flip;
    dm_slow <= slow;
    dm_go   <= 1'b1;
    @(posedge sys_clk_i);
    dm_go <= 1'b0;
    while (sec_done !== 1'b1) @(posedge sys_clk_i);
    chk("sector error", err, exp);
  endtask : send_sec

  task automatic sfz_run(input int len, input int bad, input logic exp);
    int          n;
    logic [7:0]  v;
    @(posedge sys_clk_i);
    sfz_start <= 1'b1;
    @(posedge sys_clk_i);
    sfz_start <= 1'b0;
    for (n = 0; n < len; n++) begin
      v = n < 18 ? cur[143 - 8 * n -: 8] : (n < 512 ? 8'h00 : 8'hFF);
      sfz_valid <= 1'b1;
      sfz_byte  <= (n == bad) ? ~v : v;
      @(posedge sys_clk_i);
    end
    sfz_valid <= 1'b0;
    while (sfz_done !== 1'b1) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    chk("format error", err, exp);
  endtask : sfz_run

  task automatic t_axi;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(REG_STATUS, d, r);
    chk("status at reset", d, 32'h0);
    axi_wr(REG_CTRL, 32'h3, r);
    chk("ctrl write", r, RESP_OKAY);
    axi_rd(REG_CTRL, d, r);
    chk("ctrl", d, 32'h3);
    axi_wr(8'h44, 32'h0, r);
    chk("unmapped write", r, RESP_SLVERR);
    axi_rd(8'h40, d, r);
    chk("unmapped read", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
  endtask : t_axi

  task automatic t_crc;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    c = crc_of(8'h02, media(1'b0));
    send_sec(8'h02, media(1'b0), 8'h00, 1'b1, 1'b0);
    chk("outer 2k", outer, 24'hFFFE6B);
    chk("inner 2k", inner, 24'h024CE9);
    axi_rd(REG_STATUS, d, r);
    chk("status", {d[31:8], d[1]}, {c, c, 8'h02, 1'b1});
    send_sec(8'h02, media(1'b0), 8'h01, 1'b0, 1'b1);
    axi_rd(REG_STATUS, d, r);
    chk("bad check", {d[31:16], d[1]}, {c ^ 8'h01, c, 1'b0});
    send_sec(8'h00, media(1'b1), 8'h00, 1'b0, 1'b0);
    chk("outer 4k", outer, 24'hFFFE93);
    chk("inner 4k", inner, 24'h016D79);
  endtask : t_crc

  task automatic t_fields;
    logic [19:0]  tbl [24] = '{20'h0_00_E2, 20'h0_00_63, 20'h0_01_54,
      20'h0_01_2C, 20'h0_01_44, 20'h0_02_07, 20'h0_04_5F, 20'h0_04_DE,
      20'h0_04_F2, 20'h0_05_5D, 20'h0_06_3B, 20'h0_06_51, 20'h1_06_50,
      20'h0_07_21, 20'h0_08_FD, 20'h0_09_6B, 20'h0_0A_4C, 20'h0_0B_E9,
      20'h0_0C_40, 20'h0_0D_FE, 20'h0_0E_FE, 20'h0_0F_02, 20'h1_10_00,
      20'h1_11_FF};
    logic [143:0] d;
    logic [31:0]  f;
    logic [1:0]   r;
    logic [4:0]   ix;
    foreach (tbl[i]) begin
      d = media(1'b1);
      ix = tbl[i][12:8];
      d[143 - 8 * ix -: 8] = tbl[i][7:0];
      send_sec(8'h01, d, 8'h00, 1'b0, !tbl[i][16]);
      axi_rd(REG_FIELDS, f, r);
      chk("fields", f, tbl[i][16] ? 32'h0 : 32'h1 << ix);
    end
  endtask : t_fields

  task automatic t_sfz;
    logic [31:0] d;
    logic [1:0]  r;
    send_sec(8'h00, media(1'b1), 8'h00, 1'b0, 1'b0);
    axi_rd(REG_DATA0, d, r);
    chk("data0", d, {cur[119:112], cur[127:120], cur[135:128],
                     cur[143:136]});
    sfz_run(4096, 9999, 1'b0);
    sfz_run(4096, 5, 1'b1);
    sfz_run(4096, 4095, 1'b1);
    send_sec(8'h01, media(1'b0), 8'h00, 1'b1, 1'b0);
    sfz_run(2048, 17, 1'b1);
    sfz_run(2048, 300, 1'b0);
  endtask : t_sfz

  initial begin
    sfz_start = 1'b0;
    sfz_valid = 1'b0;
    sfz_byte  = 8'h00;
    dm_go     = 1'b0;
    dm_slow   = 1'b0;
    dm_sec    = 8'h00;
    dm_crc    = 8'h00;
    dm_dat    = '0;
    axi_req   = '0;
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_axi;
    t_crc;
    t_fields;
    t_sfz;
    close_out;
  end

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    errors++;
    close_out;
  end
endmodule : test_control_track_sector_checker
